// >>> hw/crd_delay_line.sv
`timescale 1ns/1ps
module crd_delay_line
    import crd_pkg::*;
#(
    parameter int unsigned N_STAGES = STAGES,
    parameter int unsigned PW_MIN   = PW_MIN_CYC,
    parameter int unsigned PW_MAX   = PW_MAX_CYC
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Settings
    input  wire logic [DIV_W-1:0] div_set,
    input  wire logic [PW_W-1:0]  pw_set,
    // Reject path
    crd_rej_if.dst                rj,
    // Observation
    output logic                  tick,
    output logic                  sol
);

    typedef struct packed {
        logic [N_STAGES-1:0] sr;
        logic [DIV_W-1:0]    div;
        logic                prev;
        logic                held;
        logic [PW_W-1:0]     pw;
        logic                tick;
    } crd_dl_t;

    crd_dl_t s_r, s_nxt;
    logic [DIV_W-1:0] div_lim;
    logic [PW_W-1:0]  pw_lim;

    always_comb begin
        // Clamp settings to their legal ranges
        div_lim = div_set;
        if (div_set < DIV_W'(DLY_DIV_MIN)) begin
            div_lim = DIV_W'(DLY_DIV_MIN); // see (RULE12) (RULE18)
        end else if (div_set > DIV_W'(DLY_DIV_MAX)) begin
            div_lim = DIV_W'(DLY_DIV_MAX); // see (RULE12)
        end
        pw_lim = pw_set;
        if (pw_set < PW_W'(PW_MIN)) begin
            pw_lim = PW_W'(PW_MIN); // see (RULE15)
        end else if (pw_set > PW_W'(PW_MAX)) begin
            pw_lim = PW_W'(PW_MAX); // see (RULE15)
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = rj.reject;
        s_nxt.tick = 1'b0;
        // Free running delay clock
        if (s_r.div >= div_lim - DIV_W'(1)) begin
            s_nxt.div  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + DIV_W'(1);
        end
        // Shape to edge, hold until the next delay tick
        if (rj.reject && !s_r.prev) begin
            s_nxt.held = 1'b1; // see (RULE13) (RULE17)
        end
        if (s_r.tick) begin
            s_nxt.sr   = {s_r.sr[N_STAGES-2:0], s_r.held}; // see (RULE11) (RULE13) (RULE16)
            s_nxt.held = rj.reject && !s_r.prev;
            if (s_r.sr[N_STAGES-1]) begin
                s_nxt.pw = pw_lim; // see (RULE14) (RULE15)
            end
        end
        if (s_nxt.pw == s_r.pw && s_r.pw != '0) begin
            s_nxt.pw = s_r.pw - PW_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick    = s_r.tick;
    assign sol     = (s_r.pw != '0);
    assign rj.fire = sol;

endmodule

// >>> hw/crd_monitor.sv
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Beam clear starts the enable window timer
// (RULE2) Count oscillator pulses only inside window
// (RULE3) Hold count after window until next
// (RULE4) Held count drives the display
// (RULE5) Count between limits passes container
// (RULE6) Count below lower limit rejects
// (RULE7) Upper limit 99 disables upper check
// (RULE8) Lower limit 00 disables lower check
// (RULE9) Reject needs comparator and timer coincidence
// (RULE10) Variable-rate unit takes reject instead
// (RULE11) 128-stage register steps per delay tick
// (RULE12) Delay clock adjustable 23 Hz to 25 kHz
// (RULE13) Reject shaped, held, injected next tick
// (RULE14) Output appears 128 ticks later
// (RULE15) One solenoid pulse, 5 to 55 ms
// (RULE16) Error only from tick synchronization
// (RULE17) Two rejects per tick merge
// (RULE18) Fastest delay clock gives shortest delay
// (RULE19) Counter spans 0 to 99
// (RULE20) Count above upper limit rejects
// (RULE21) Disable switch blocks rejector pulse only
// (RULE22) Lower indicator holds until upper reject
// (RULE23) Inputs synchronized and edge detected
module crd_monitor
    import crd_pkg::*;
#(
    parameter int unsigned ENABLE_CYCLES = ENABLE_CYC,
    parameter int unsigned N_STAGES      = STAGES,
    parameter int unsigned PW_MIN_CYCLES = PW_MIN_CYC,
    parameter int unsigned PW_MAX_CYCLES = PW_MAX_CYC
) (
    // Clock and reset
    input  wire logic             CLOCK,
    input  wire logic             RST_N,
    // Sensors
    input  wire logic             PHOTO_ON,
    input  wire logic             OSC_PULSE,
    // Operator settings
    input  wire logic [CNT_W-1:0] UPPER_LIMIT,
    input  wire logic [CNT_W-1:0] LOWER_LIMIT,
    input  wire logic [DIV_W-1:0] DELAY_DIV,
    input  wire logic [PW_W-1:0]  PULSE_WIDTH,
    input  wire logic             DISABLE_SW,
    input  wire logic             VRR_FITTED,
    // Display and indicators
    output logic [CNT_W-1:0]      COUNT_DISPLAY,
    output logic                  ENABLE_WINDOW,
    output logic                  REJECT_FLASH,
    output logic                  LOWER_IND,
    output logic                  UPPER_IND,
    // Reject outputs
    output logic                  VRR_REJECT,
    output logic                  SOLENOID,
    output logic                  DELAY_TICK
);

    typedef struct packed {
        logic [1:0]       ph_sy;
        logic [1:0]       os_sy;
        logic             ph_d;
        logic             os_d;
        crd_state_t       st;
        logic [TMR_W-1:0] en_t;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] hold;
        logic [TMR_W-1:0] rj_t;
        logic             cmp_lo;
        logic             cmp_hi;
        logic             gate;
        logic             flash;
        logic             lo_ind;
        logic             hi_ind;
        logic             vrr;
    } crd_mon_t;

    crd_mon_t s_r, s_nxt;
    logic     ph_rise;
    logic     os_rise;
    logic     lo_rej;
    logic     hi_rej;

    crd_rej_if rif ();

    // ------------------------------------------------------------
    // Measurement and comparison
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.ph_sy = {s_r.ph_sy[0], PHOTO_ON};   // see (RULE23)
        s_nxt.os_sy = {s_r.os_sy[0], OSC_PULSE};  // see (RULE23)
        s_nxt.ph_d  = s_r.ph_sy[1];
        s_nxt.os_d  = s_r.os_sy[1];
        ph_rise = s_r.ph_sy[1] && !s_r.ph_d;      // see (RULE23)
        os_rise = s_r.os_sy[1] && !s_r.os_d;      // see (RULE23)
        lo_rej = (LOWER_LIMIT != LOWER_OFF) && (s_r.hold < LOWER_LIMIT); // see (RULE6) (RULE8)
        hi_rej = (UPPER_LIMIT != UPPER_OFF) && (s_r.hold > UPPER_LIMIT); // see (RULE20) (RULE7)
        s_nxt.gate  = 1'b0;
        s_nxt.flash = 1'b0;
        if (s_r.rj_t != '0) begin
            s_nxt.rj_t = s_r.rj_t - TMR_W'(1);
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (ph_rise) begin
                    s_nxt.st   = ST_COUNT;                 // see (RULE1)
                    s_nxt.en_t = TMR_W'(ENABLE_CYCLES);
                    s_nxt.cnt  = '0;                       // see (RULE3)
                end
            end
            ST_COUNT: begin
                if (os_rise && s_r.cnt != CNT_MAX) begin
                    s_nxt.cnt = s_r.cnt + CNT_W'(1);       // see (RULE2) (RULE19)
                end
                if (s_r.en_t <= TMR_W'(1)) begin
                    s_nxt.st   = ST_JUDGE;
                    s_nxt.hold = s_nxt.cnt;                // see (RULE3) (RULE4)
                end else begin
                    s_nxt.en_t = s_r.en_t - TMR_W'(1);
                end
            end
            ST_JUDGE: begin
                s_nxt.st     = ST_IDLE;
                s_nxt.cmp_lo = lo_rej;                     // see (RULE5)
                s_nxt.cmp_hi = hi_rej;                     // see (RULE5)
                if (lo_rej || hi_rej) begin
                    s_nxt.rj_t = TMR_W'(RJT_CYC);
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // Reject gate: comparator result coincident with reject timer
        if ((s_r.cmp_lo || s_r.cmp_hi) && s_r.rj_t != '0) begin
            s_nxt.flash = 1'b1;                            // see (RULE9)
            s_nxt.gate  = !DISABLE_SW;                     // see (RULE21)
            if (s_r.cmp_hi) begin
                s_nxt.hi_ind = 1'b1;
                s_nxt.lo_ind = 1'b0;                       // see (RULE22)
            end else begin
                s_nxt.lo_ind = 1'b1;                       // see (RULE22)
                s_nxt.hi_ind = 1'b0;
            end
        end
        if (s_r.rj_t == TMR_W'(1) && s_r.st != ST_JUDGE) begin
            s_nxt.cmp_lo = 1'b0;
            s_nxt.cmp_hi = 1'b0;
        end
        s_nxt.vrr = s_nxt.gate && VRR_FITTED;              // see (RULE10)
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            s_r    <= '0;
            s_r.st <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Delay line and solenoid
    // ------------------------------------------------------------
    assign rif.reject = s_r.gate && !VRR_FITTED;           // see (RULE10)

    crd_delay_line #(
        .N_STAGES (N_STAGES),
        .PW_MIN   (PW_MIN_CYCLES),
        .PW_MAX   (PW_MAX_CYCLES)
    ) u_dl (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .div_set (DELAY_DIV),
        .pw_set  (PULSE_WIDTH),
        .rj      (rif.dst),
        .tick    (DELAY_TICK),
        .sol     ()
    );

    assign SOLENOID      = rif.fire;                       // see (RULE15)

    assign COUNT_DISPLAY = s_r.hold;                       // see (RULE4)
    assign ENABLE_WINDOW = (s_r.st == ST_COUNT);
    assign REJECT_FLASH  = s_r.flash;
    assign LOWER_IND     = s_r.lo_ind;
    assign UPPER_IND     = s_r.hi_ind;
    assign VRR_REJECT    = s_r.vrr;

endmodule

// >>> inc/crd_pkg.sv
package crd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned DLY_FMIN_HZ       = 23;
    localparam int unsigned DLY_FMAX_HZ       = 25_000;
    localparam int unsigned DLY_DIV_MIN       = CLK_HZ / DLY_FMAX_HZ;
    localparam int unsigned DLY_DIV_MAX       = CLK_HZ / DLY_FMIN_HZ;
    localparam int unsigned PW_MIN_MS         = 5;
    localparam int unsigned PW_MAX_MS         = 55;
    localparam int unsigned PW_MIN_CYC        = (CLK_HZ / 1000) * PW_MIN_MS;
    localparam int unsigned PW_MAX_CYC        = (CLK_HZ / 1000) * PW_MAX_MS;
    localparam int unsigned MIN_DELAY_MS      = 15;
    localparam int unsigned ENABLE_US         = 10_000;
    localparam int unsigned ENABLE_CYC        = (CLK_HZ / 1_000_000) * ENABLE_US;
    localparam int unsigned RJT_US            = 100;
    localparam int unsigned RJT_CYC           = (CLK_HZ / 1_000_000) * RJT_US;

    // ------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------
    localparam int unsigned STAGES            = 128;
    localparam int unsigned CNT_W             = 7;
    localparam logic [6:0]  CNT_MAX           = 7'h63;
    localparam logic [6:0]  UPPER_OFF         = 7'h63;
    localparam logic [6:0]  LOWER_OFF         = 7'h00;
    localparam int unsigned DIV_W             = 20;
    localparam int unsigned PW_W              = 21;
    localparam int unsigned TMR_W             = 18;

    // ------------------------------------------------------------
    // Measurement window states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_COUNT = 3'b010,
        ST_JUDGE = 3'b100
    } crd_state_t;

endpackage

// >>> inc/crd_rej_if.sv
`timescale 1ns/1ps
interface crd_rej_if;
    logic reject;
    logic fire;
    modport src (output reject, input fire);
    modport dst (input reject, output fire);
endinterface

// >>> testbench/crd_monitor_assertions.sv
`timescale 1ns/1ps
module crd_monitor_assertions
    import crd_pkg::*;
#(
    parameter int unsigned ENABLE_CYCLES = ENABLE_CYC,
    parameter int unsigned N_STAGES      = STAGES
) (
    // Sensor, settings and count
    input wire logic             CLOCK, RST_N, PHOTO_ON, DISABLE_SW, VRR_FITTED,
    input wire logic [CNT_W-1:0] UPPER_LIMIT, LOWER_LIMIT, COUNT_DISPLAY,
    input wire logic [DIV_W-1:0] DELAY_DIV,
    input wire logic [PW_W-1:0]  PULSE_WIDTH,
    // Indicators and reject outputs
    input wire logic             ENABLE_WINDOW, REJECT_FLASH, LOWER_IND, UPPER_IND,
    input wire logic             VRR_REJECT, SOLENOID, DELAY_TICK
);
    logic [31:0] win_r, tk_r, sol_r;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ------------------------------------------------------------
    // Cycle counters
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        win_r <= (RST_N && ENABLE_WINDOW) ? win_r + 32'h0000_0001 : 32'h0000_0000;
        sol_r <= (RST_N && SOLENOID) ? sol_r + 32'h0000_0001 : 32'h0000_0000;
        tk_r  <= !RST_N ? 32'h0000_0000 : DELAY_TICK ? 32'h0000_0001 : tk_r + 32'(tk_r != 0);
    end
    sequence photo_rise;
        $rose(PHOTO_ON) ##0 !ENABLE_WINDOW;
    endsequence
    chk_window_start: assert property (photo_rise |-> ##[2:4] ENABLE_WINDOW)
        else $error("window did not open");
    chk_window_cause: assert property ($rose(ENABLE_WINDOW) |-> $past(PHOTO_ON, 3))
        else $error("window opened without beam clear");
    chk_window_len: assert property ($fell(ENABLE_WINDOW) |-> win_r == ENABLE_CYCLES)
        else $error("window length wrong");
    chk_hold_count: assert property ((!ENABLE_WINDOW)[*4] |-> $stable(COUNT_DISPLAY))
        else $error("held count changed");
    chk_count_range: assert property (COUNT_DISPLAY <= CNT_MAX)
        else $error("count above range");
    chk_flash_cause: assert property ($rose(REJECT_FLASH) |->
        (UPPER_LIMIT != UPPER_OFF && COUNT_DISPLAY > UPPER_LIMIT) ||
        (LOWER_LIMIT != LOWER_OFF && COUNT_DISPLAY < LOWER_LIMIT)) else $error("flash without fault");
    chk_ind_excl: assert property (!(LOWER_IND && UPPER_IND))
        else $error("both indicators lit");
    chk_vrr_route: assert property (VRR_REJECT |-> VRR_FITTED && !DISABLE_SW)
        else $error("reject routed wrongly");
    chk_tick_period: assert property (DELAY_TICK && tk_r != 0 |->
        tk_r == 32'(DELAY_DIV) ##1 !DELAY_TICK) else $error("tick spacing wrong");
    chk_sol_tick: assert property ($rose(SOLENOID) |-> $past(DELAY_TICK))
        else $error("solenoid not on tick");
    chk_sol_width: assert property ($fell(SOLENOID) |-> sol_r == 32'(PULSE_WIDTH))
        else $error("solenoid width wrong");
endmodule
bind crd_monitor crd_monitor_assertions #(.ENABLE_CYCLES(ENABLE_CYCLES), .N_STAGES(N_STAGES)) i_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .PHOTO_ON(PHOTO_ON), .DISABLE_SW(DISABLE_SW), .VRR_FITTED(VRR_FITTED),
    .UPPER_LIMIT(UPPER_LIMIT), .LOWER_LIMIT(LOWER_LIMIT), .COUNT_DISPLAY(COUNT_DISPLAY),
    .DELAY_DIV(DELAY_DIV), .PULSE_WIDTH(PULSE_WIDTH), .ENABLE_WINDOW(ENABLE_WINDOW),
    .REJECT_FLASH(REJECT_FLASH), .LOWER_IND(LOWER_IND), .UPPER_IND(UPPER_IND),
    .VRR_REJECT(VRR_REJECT), .SOLENOID(SOLENOID), .DELAY_TICK(DELAY_TICK));

// >>> testbench/crd_solenoid.sv
`timescale 1ns/1ps
module crd_solenoid (
    // Drive from the monitor
    input  wire logic clk,
    input  wire logic drive,
    // Stroke tally
    output int        strokes
);
    logic drive_d = 1'b0;
    initial strokes = 0;
    always @(posedge clk) begin
        drive_d <= drive;
        if (drive === 1'b1 && drive_d !== 1'b1) begin
            strokes <= strokes + 1;
        end
    end
endmodule

// >>> testbench/tb_crd_monitor.sv
`timescale 1ns/1ps
module tb_crd_monitor import crd_pkg::*;;
    logic             CLOCK = 1'b0, RST_N = 1'b0, PHOTO_ON = 1'b0, OSC_PULSE = 1'b0;
    logic             DISABLE_SW = 1'b0, VRR_FITTED = 1'b1, li = 1'b0, ui = 1'b0, flash_d = 1'b0;
    logic [CNT_W-1:0] UPPER_LIMIT = 7'h4b, LOWER_LIMIT = 7'h19, COUNT_DISPLAY;
    logic [DIV_W-1:0] DELAY_DIV = 20'h0_0320;
    logic [PW_W-1:0]  PULSE_WIDTH = 21'h00_0bb8;
    logic             ENABLE_WINDOW, REJECT_FLASH, LOWER_IND, UPPER_IND, VRR_REJECT, SOLENOID, DELAY_TICK;
    logic [31:0]      seed = 32'hba87_f657;
    logic [10:0]      notes[$];
    logic [10:0]      exp_m, got_m;
    int               error_cnt = 0, checks = 0, strokes, tk = 0;
    int               cases[4] = '{0, 40, 80, 110};
    crd_monitor #(.ENABLE_CYCLES(500), .N_STAGES(8), .PW_MIN_CYCLES(2000), .PW_MAX_CYCLES(22000)) i_dut (
        .CLOCK(CLOCK), .RST_N(RST_N), .PHOTO_ON(PHOTO_ON), .OSC_PULSE(OSC_PULSE),
        .UPPER_LIMIT(UPPER_LIMIT), .LOWER_LIMIT(LOWER_LIMIT), .DELAY_DIV(DELAY_DIV),
        .PULSE_WIDTH(PULSE_WIDTH), .DISABLE_SW(DISABLE_SW), .VRR_FITTED(VRR_FITTED),
        .COUNT_DISPLAY(COUNT_DISPLAY), .ENABLE_WINDOW(ENABLE_WINDOW), .REJECT_FLASH(REJECT_FLASH),
        .LOWER_IND(LOWER_IND), .UPPER_IND(UPPER_IND), .VRR_REJECT(VRR_REJECT),
        .SOLENOID(SOLENOID), .DELAY_TICK(DELAY_TICK));
    crd_solenoid i_sol (.clk(CLOCK), .drive(SOLENOID), .strokes(strokes));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(string what, logic [10:0] exp, logic [10:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic osc(int k);
        repeat (k) begin
            OSC_PULSE = 1'b1;
            repeat (2) @(negedge CLOCK);
            OSC_PULSE = 1'b0;
            repeat (2) @(negedge CLOCK);
        end
    endtask
    task automatic measure(int n);
        logic       lr, ur, vr;
        logic [6:0] c;
        c  = (n > 99) ? 7'h63 : 7'(n);
        lr = LOWER_LIMIT != LOWER_OFF && c < LOWER_LIMIT;
        ur = UPPER_LIMIT != UPPER_OFF && c > UPPER_LIMIT;
        if (lr) {li, ui} = 2'b10;
        if (ur) {li, ui} = 2'b01;
        vr = (lr | ur) && VRR_FITTED && !DISABLE_SW;
        notes.push_back({vr, li, ui, lr | ur, c});
        PHOTO_ON = 1'b1;
        repeat (6) @(negedge CLOCK);
        osc(n);
        PHOTO_ON = 1'b0;
        repeat (520 - 4 * n) @(negedge CLOCK);
        osc(3);
        repeat (2200) @(negedge CLOCK);
        $display("test measure %0d done", n);
    endtask
    // ------------------------------------------------------------
    // Clock, watchers and sequence
    // ------------------------------------------------------------
    initial forever #25 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        flash_d <= REJECT_FLASH;
        if (REJECT_FLASH === 1'b1 && flash_d !== 1'b1) begin
            tk <= 0;
        end else if (DELAY_TICK === 1'b1) begin
            tk <= tk + 1;
        end
    end
    initial forever begin
        @(negedge ENABLE_WINDOW iff RST_N);
        repeat (4) @(negedge CLOCK);
        exp_m = notes.size() ? notes.pop_front() : 11'h7ff;
        got_m = {VRR_REJECT, LOWER_IND, UPPER_IND, REJECT_FLASH, COUNT_DISPLAY};
        cmp("measure", exp_m, got_m);
    end
    initial begin
        repeat (5) @(negedge CLOCK);
        RST_N = 1'b1;
        osc(4);
        foreach (cases[i]) measure(cases[i]);
        {UPPER_LIMIT, LOWER_LIMIT} = {7'h63, 7'h00};
        measure(110);
        measure(0);
        {UPPER_LIMIT, LOWER_LIMIT} = {7'h1e, 7'h0a};
        repeat (2) begin
            seed = lfsr(seed);
            measure(int'(seed % 100));
        end
        {DISABLE_SW, VRR_FITTED, LOWER_LIMIT} = {2'b10, 7'h19};
        measure(0);
        DISABLE_SW = 1'b0;
        measure(0);
        for (int i = 0; i < 20000 && SOLENOID !== 1'b1; i++) @(negedge CLOCK);
        cmp("delay_ticks", 11'h001, {10'h000, SOLENOID === 1'b1 && tk >= 8 && tk <= 9});
        if (SOLENOID !== 1'b1) tally_and_finish();
        for (int i = 0; i < 8000 && SOLENOID !== 1'b0; i++) @(negedge CLOCK);
        cmp("sol_strokes", 11'h001, {SOLENOID, 10'(strokes)});
        cmp("pending", 11'h000, 11'(notes.size()));
        $display("test delay line done");
        tally_and_finish();
    end
endmodule
